// ==== bcdu_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcdu_formatter import bcdu_pkg::*; #(
	parameter int CYCLE_CLKS = CONV_CYCLE_CLKS
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Converter result port
	input  wire logic        strobe_n,
	input  wire logic [4:0]  digit_sel,
	input  wire logic [3:0]  bcd,
	input  wire logic        sign,
	input  wire logic        over_range,
	input  wire logic        under_range,
	input  wire logic        busy,
	output logic             run_hold,
	// Local result view
	output logic [15:0]      result_digits,
	output logic             result_sign,
	output logic             result_over,
	output logic             display_blank,
	output logic             conv_tick,
	// Link to controller
	bcdu_link_if.dev         link
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic [2:0] sel_index(input logic [4:0] sel);
		sel_index = 3'd0;
		for (int i = 0; i < 5; i++) begin
			if (sel[i]) sel_index = 3'(4 - i);
		end
	endfunction : sel_index

	function automatic logic [3:0] word_tag(input logic [2:0] idx);
		word_tag = (idx == 3'd0) ? TAG_TOP : 4'(TAG_NEXT >> (idx - 3'd1));
	endfunction : word_tag

	logic        load_pulse;
	logic [2:0]  idx;
	logic [3:0]  nib;
	logic [7:0]  word_reg;
	logic        load_reg;
	logic        eps_reg;
	logic        busy_reg;
	logic        top_reg;
	logic        run_reg;
	logic [15:0] collect_reg;
	logic        sign_cap;
	logic        over_cap;
	logic        phase_reg;
	logic [2:0]  cnt_reg;
	logic [15:0] cyc_reg;
	bcdu_burst_t state_reg;

	bcdu_strobe_sync u_sync (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.strobe_n   (strobe_n),
		.load_pulse (load_pulse)
	);

	// Word index and nibble, flags merged into the top digit
	always_comb begin
		idx = sel_index(digit_sel);
		nib = bcd;
		if (digit_sel[4] && link.merge_flags) begin
			nib[SIGN_POS]  = sign;
			nib[OVER_POS]  = over_range;
			nib[UNDER_POS] = under_range;
		end
	end

	// ----------------------------------------
	// Word stream toward the controller
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_reg <= 8'h00;
			load_reg <= 1'b0;
			eps_reg  <= 1'b0;
		end else begin
			load_reg <= load_pulse;
			if (load_pulse) begin
				word_reg <= {word_tag(idx), nib};
				if (digit_sel[4]) eps_reg <= sign; // Held over the stream
			end
		end
	end

	// Converter status passed across, run/hold from controller
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg <= 1'b0;
			top_reg  <= 1'b0;
			run_reg  <= 1'b0;
		end else begin
			busy_reg <= busy;
			top_reg  <= digit_sel[4];
			run_reg  <= link.start_req | ~link.hold_req;
		end
	end

	// ----------------------------------------
	// Burst collection and local display
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg   <= B_IDLE;
			cnt_reg     <= 3'd0;
			collect_reg <= 16'h0000;
			sign_cap    <= 1'b0;
			over_cap    <= 1'b0;
			phase_reg   <= 1'b0;
			result_digits <= 16'h0000;
			result_sign <= 1'b0;
			result_over <= 1'b0;
		end else begin
			if (load_pulse && digit_sel[4]) begin
				state_reg <= B_RUN;
				cnt_reg   <= 3'd1;
				sign_cap  <= sign;
				over_cap  <= over_range;
			end else begin
				case (state_reg)
					B_IDLE: begin
						cnt_reg <= 3'd0;
					end
					B_RUN: begin
						if (load_pulse) begin
							cnt_reg <= cnt_reg + 3'd1;
						end else if (cnt_reg == 3'(NUM_WORDS)) begin
							state_reg     <= B_IDLE;
							result_sign   <= sign_cap;
							result_over   <= over_cap;
							result_digits <= over_cap ? 16'h0000 : collect_reg;
							phase_reg     <= over_cap & ~phase_reg;
						end
					end
					default: begin
						state_reg <= B_IDLE;
					end
				endcase
			end
			for (int k = 1; k < 5; k++) begin
				if (load_pulse && idx == 3'(k)) collect_reg[(4 - k) * 4 +: 4] <= bcd;
			end
		end
	end

	// Conversion period timer, aligned on the top-digit word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_reg   <= 16'h0000;
			conv_tick <= 1'b0;
		end else begin
			conv_tick <= 1'b0;
			if (load_pulse && digit_sel[4]) begin
				cyc_reg <= 16'h0000;
			end else if (cyc_reg == 16'(CYCLE_CLKS - 1)) begin
				cyc_reg   <= 16'h0000;
				conv_tick <= 1'b1;
			end else begin
				cyc_reg <= cyc_reg + 16'h0001;
			end
		end
	end

	assign display_blank           = over_cap & phase_reg;
	assign run_hold                = run_reg;
	assign link.word               = word_reg;
	assign link.load               = load_reg;
	assign link.even_parity_select = eps_reg;
	assign link.busy               = busy_reg;
	assign link.top_digit_select   = top_reg;
endmodule : bcdu_formatter
`default_nettype wire

// ==== bcdu_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface bcdu_link_if;
	// Formatter to controller
	logic [7:0] word;
	logic       load;
	logic       even_parity_select;
	logic       busy;
	logic       top_digit_select;
	// Controller to formatter
	logic       start_req;
	logic       hold_req;
	logic       merge_flags;

	modport dev (
		output word, load, even_parity_select, busy, top_digit_select,
		input  start_req, hold_req, merge_flags
	);
	modport host (
		input  word, load, even_parity_select, busy, top_digit_select,
		output start_req, hold_req, merge_flags
	);
endinterface : bcdu_link_if
`default_nettype wire

// ==== bcdu_link_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcdu_link_props import bcdu_pkg::*; (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Formatter to controller
	input  wire logic [7:0] word,
	input  wire logic       load,
	input  wire logic       even_parity_select,
	input  wire logic       busy,
	input  wire logic       top_digit_select,
	// Controller to formatter
	input  wire logic       start_req,
	input  wire logic       hold_req,
	input  wire logic       merge_flags
);
	logic [3:0] last_tag;
	logic       top_load;

	// Tag of the previous word on the link
	always_ff @(posedge aclk) begin
		if (!aresetn)
			last_tag <= TAG_TOP;
		else if (load)
			last_tag <= word[7:4];
	end
	assign top_load = load && (word[7:4] == TAG_TOP);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_load_one_cycle: assert property (load |=> !load)
		else $error("load pulse wider than one cycle");
	a_tag_legal: assert property (load |-> word[7:4] inside {4'h0, 4'h8, 4'h4, 4'h2, 4'h1})
		else $error("word carries an unknown digit tag");
	a_tag_order: assert property (load && !top_load |->
		word[7:4] == ((last_tag == TAG_TOP) ? TAG_NEXT : (last_tag >> 1)))
		else $error("digit tag out of sequence");
	a_word_stands: assert property (!load |-> $stable(word))
		else $error("word changed without a load");
	a_parity_stands: assert property (!top_load |-> $stable(even_parity_select))
		else $error("parity select changed inside a stream");
	a_merge_sign: assert property (top_load && merge_flags |->
		word[SIGN_POS] == even_parity_select)
		else $error("merged sign differs from parity select");
	a_busy_clears: assert property ($rose(busy) |-> ##[1:4] !start_req)
		else $error("busy did not clear the start request");
	a_start_holds: assert property (start_req && !busy |=> start_req)
		else $error("start request dropped before busy");
endmodule : bcdu_link_props
`default_nettype wire

// ==== bcdu_pkg.sv ====
package bcdu_pkg;

	// ----------------------------------------
	// Stream shape
	// ----------------------------------------
	localparam int         NUM_WORDS       = 5;
	localparam logic [3:0] TAG_TOP         = 4'h0;
	localparam logic [3:0] TAG_NEXT        = 4'h8;
	localparam int         SIGN_POS        = 1;
	localparam int         OVER_POS        = 2;
	localparam int         UNDER_POS       = 3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ         = 200;
	localparam int CONV_CYCLE_CLKS = 40002;
	localparam int BIT_TIME_NS     = 1000;
	localparam int BIT_CLKS        = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int WORD_BITS       = 11;
	localparam int WORD_CLKS       = BIT_CLKS * WORD_BITS;

	// ----------------------------------------
	// Controller registers
	// ----------------------------------------
	localparam logic [7:0]  CTRL_OFS     = 8'h00;
	localparam logic [7:0]  STATUS_OFS   = 8'h04;
	localparam logic [7:0]  WORD_OFS     = 8'h08;
	localparam logic [7:0]  READING_OFS  = 8'h0c;
	localparam logic [7:0]  IRQ_STAT_OFS = 8'h10;
	localparam logic [7:0]  IRQ_EN_OFS   = 8'h14;
	localparam logic [7:0]  IRQ_CLR_OFS  = 8'h18;
	localparam int          CTRL_START   = 0;
	localparam int          CTRL_HOLD    = 1;
	localparam int          CTRL_MERGE   = 2;
	localparam logic [2:0]  CTRL_RST     = 3'h0;
	localparam int          ST_BUSY      = 0;
	localparam int          ST_READY     = 1;
	localparam int          ST_TX        = 2;
	localparam int          IRQ_WORD     = 0;
	localparam int          IRQ_READING  = 1;
	localparam int          IRQ_OVERRUN  = 2;
	localparam logic [2:0]  IRQ_RST      = 3'h0;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_ERR     = 2'h2;

	// Burst tracking in the formatter
	typedef enum logic [1:0] {
		B_IDLE = 2'b01,
		B_RUN  = 2'b10
	} bcdu_burst_t;

endpackage : bcdu_pkg

// ==== bcdu_strobe_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcdu_strobe_sync (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Strobe in, pulse out
	input  wire logic strobe_n,
	output logic      load_pulse
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// Two-stage synchroniser, then falling edge to one pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg   <= 1'b1;
			sync_reg   <= 1'b1;
			prev_reg   <= 1'b1;
			load_pulse <= 1'b0;
		end else begin
			meta_reg   <= strobe_n;
			sync_reg   <= meta_reg;
			prev_reg   <= sync_reg;
			load_pulse <= prev_reg & ~sync_reg;
		end
	end
endmodule : bcdu_strobe_sync
`default_nettype wire

// ==== bcdu_top_note_placeholder.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bcdu_uart_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcdu_uart_ctrl import bcdu_pkg::*; (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial command and display side
	input  wire logic        uart_serial_input,
	output logic             ripple_blank_input,
	output logic             irq,
	// Link to formatter
	bcdu_link_if.host        link
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [2:0] tag_slot(input logic [3:0] tag);
		case (tag)
			4'h0:    tag_slot = 3'd0;
			4'h8:    tag_slot = 3'd1;
			4'h4:    tag_slot = 3'd2;
			4'h2:    tag_slot = 3'd3;
			4'h1:    tag_slot = 3'd4;
			default: tag_slot = 3'd7;
		endcase
	endfunction : tag_slot

	function automatic logic known(input logic [7:0] a);
		known = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == WORD_OFS) ||
			(a == READING_OFS) || (a == IRQ_STAT_OFS) || (a == IRQ_EN_OFS) ||
			(a == IRQ_CLR_OFS);
	endfunction : known

	logic [7:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	logic        do_write;
	logic [2:0]  ctrl_reg;
	logic        ready_reg;
	logic        busy_d;
	logic [7:0]  word_reg;
	logic        eps_cap;
	logic        perr;
	logic [19:0] reading_reg;
	logic [11:0] tx_cnt;
	logic [2:0]  ev;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_en_reg;
	logic [2:0]  clr;
	logic        start_wr;
	logic        rblank_reg;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write      = aw_held & w_held & ~s_axi_bvalid;
	assign start_wr      = do_write && aw_addr == CTRL_OFS && w_strb[0] && w_data[CTRL_START];
	assign clr           = (do_write && aw_addr == IRQ_CLR_OFS && w_strb[0]) ? w_data[2:0] : 3'h0;

	// Address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known(aw_addr) ? RESP_OK : RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control and enable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg   <= CTRL_RST;
			irq_en_reg <= IRQ_RST;
		end else if (do_write && w_strb[0]) begin
			if (aw_addr == CTRL_OFS) ctrl_reg <= {w_data[CTRL_MERGE], w_data[CTRL_HOLD], 1'b0};
			if (aw_addr == IRQ_EN_OFS) irq_en_reg <= w_data[2:0];
		end
	end

	// Read mux
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= known(s_axi_araddr) ? RESP_OK : RESP_ERR;
			case (s_axi_araddr)
				CTRL_OFS:     s_axi_rdata <= {29'h0, ctrl_reg};
				STATUS_OFS:   s_axi_rdata <= {29'h0, tx_cnt != 12'h000, ready_reg, link.busy};
				WORD_OFS:     s_axi_rdata <= {23'h0, eps_cap, word_reg};
				READING_OFS:  s_axi_rdata <= {12'h0, reading_reg};
				IRQ_STAT_OFS: s_axi_rdata <= {29'h0, irq_stat_reg};
				IRQ_EN_OFS:   s_axi_rdata <= {29'h0, irq_en_reg};
				default:      s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Start command and data-ready
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_reg <= 1'b0;
			busy_d    <= 1'b0;
		end else begin
			busy_d <= link.busy;
			if (uart_serial_input || start_wr) begin
				ready_reg <= 1'b1; // Set wins over busy
			end else if (link.busy && !busy_d) begin
				ready_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Word reception and reading assembly
	// ----------------------------------------
	// Transmit parity from captured select; receiver checks odd
	assign perr = ~(^word_reg ^ (^word_reg ^ ~eps_cap)); // Error when select was high

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_reg    <= 8'h00;
			eps_cap     <= 1'b0;
			reading_reg <= 20'h00000;
			ev          <= 3'h0;
			tx_cnt      <= 12'h000;
		end else begin
			ev <= 3'h0;
			if (tx_cnt != 12'h000) tx_cnt <= tx_cnt - 12'h001;
			if (link.load) begin
				word_reg       <= link.word;
				eps_cap        <= link.even_parity_select;
				tx_cnt         <= 12'(WORD_CLKS);
				ev[IRQ_WORD]   <= 1'b1;
				ev[IRQ_OVERRUN] <= tx_cnt != 12'h000;
				case (tag_slot(link.word[7:4]))
					3'd0: begin
						reading_reg[16] <= link.word[0];
						reading_reg[18] <= ctrl_reg[CTRL_MERGE] & link.word[OVER_POS];
						reading_reg[19] <= ctrl_reg[CTRL_MERGE] & link.word[UNDER_POS];
					end
					3'd1: reading_reg[15:12] <= link.word[3:0];
					3'd2: reading_reg[11:8]  <= link.word[3:0];
					3'd3: reading_reg[7:4]   <= link.word[3:0];
					3'd4: begin
						reading_reg[3:0]  <= link.word[3:0];
						ev[IRQ_READING]   <= 1'b1;
					end
					default: reading_reg <= reading_reg;
				endcase
			end
			if (ev[IRQ_WORD] && word_reg[7:4] == TAG_TOP) begin
				reading_reg[17] <= perr; // Parity error reads as positive
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= IRQ_RST;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
		end
	end

	// Ripple blanking follows the top digit select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rblank_reg <= 1'b0;
		end else begin
			rblank_reg <= link.top_digit_select;
		end
	end

	assign irq                = |(irq_stat_reg & irq_en_reg);
	assign ripple_blank_input = rblank_reg;
	assign link.start_req     = ready_reg;
	assign link.hold_req      = ctrl_reg[CTRL_HOLD];
	assign link.merge_flags   = ctrl_reg[CTRL_MERGE];
endmodule : bcdu_uart_ctrl
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench import bcdu_pkg::*; ;
	localparam int GAP = 2300;
	logic aclk = 1'b0, aresetn = 1'b0, strobe_n = 1'b1, busy = 1'b0, uart_serial_input = 1'b0;
	logic sign = 1'b0, over_range = 1'b0, under_range = 1'b0, mg = 1'b0, db;
	logic [4:0] digit_sel = 5'h00;
	logic [3:0] bcd = 4'h0, s_axi_wstrb = 4'hf;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ew;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic run_hold, result_sign, result_over, display_blank, conv_tick, ripple_blank_input, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] result_digits;
	logic [7:0] exp_q[$];
	int miscompares = 0, n_tests = 0, ticks = 0;

	bcdu_link_if link ();
	bcdu_formatter #(.CYCLE_CLKS(50)) u_bcdu_formatter (.aclk, .aresetn, .strobe_n, .digit_sel,
		.bcd, .sign, .over_range, .under_range, .busy, .run_hold, .result_digits, .result_sign,
		.result_over, .display_blank, .conv_tick, .link(link.dev));
	bcdu_uart_ctrl u_bcdu_uart_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart_serial_input,
		.ripple_blank_input, .irq, .link(link.host));
	bcdu_link_props u_props (.aclk, .aresetn, .word(link.word), .load(link.load),
		.even_parity_select(link.even_parity_select), .busy(link.busy),
		.top_digit_select(link.top_digit_select), .start_req(link.start_req),
		.hold_req(link.hold_req), .merge_flags(link.merge_flags));

	// Clock and watchdog
	always #2.5 aclk = ~aclk;
	initial begin
		#400000;
		miscompares++;
		stop_test();
	end

	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// Link words against the model queue
	always @(negedge aclk) begin
		if (link.load === 1'b1) begin
			ew = exp_q.pop_front();
			`CHK("link word", ew, link.word)
			if (ew[7:4] == TAG_TOP) `CHK("parity select", sign, link.even_parity_select)
			`CHK("ripple blank", digit_sel[4], ripple_blank_input)
		end
		if (conv_tick === 1'b1) ticks++;
	end

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge aclk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge aclk);
			ah = s_axi_arvalid & s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic burst(input logic sg, input logic ov, input logic un, input int gap);
		logic [3:0] dg[5];
		int i;
		dg[0] = 4'($urandom_range(1, 0));
		for (i = 1; i < 5; i++) dg[i] = 4'($urandom_range(9, 0));
		@(posedge aclk);
		sign <= sg;
		over_range <= ov;
		under_range <= un;
		for (i = 0; i < 5; i++) begin
			exp_q.push_back({(i == 0) ? TAG_TOP : 4'(TAG_NEXT >> (i - 1)),
				(i == 0 && mg) ? {un, ov, sg, dg[0][0]} : dg[i]});
			@(posedge aclk);
			digit_sel <= 5'h10 >> i;
			bcd <= dg[i];
			strobe_n <= 1'b0;
			repeat (2) @(posedge aclk);
			strobe_n <= 1'b1;
			repeat (gap) @(posedge aclk);
		end
		@(negedge aclk);
		`CHK("digits", ov ? 16'h0 : {dg[1], dg[2], dg[3], dg[4]}, result_digits)
		`CHK("sign and over", {sg, ov}, {result_sign, result_over})
		axr(READING_OFS, rd, rsp);
		if (!ov) `CHK("reading digits", {dg[1], dg[2], dg[3], dg[4]}, rd[15:0])
		`CHK("reading flags", {mg & un, mg & ov, sg, dg[0][0]}, rd[19:16])
		axr(WORD_OFS, rd, rsp);
		`CHK("last word", {sg, 4'h1, dg[4]}, rd[8:0])
	endtask : burst

	// Main sequence
	initial begin
		void'($urandom(59));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(negedge aclk);
		`CHK("run after reset", 2'b10, {run_hold, irq})
		axr(CTRL_OFS, rd, rsp);
		`CHK("ctrl reset", {29'h0, CTRL_RST}, rd)
		axr(IRQ_EN_OFS, rd, rsp);
		`CHK("irq enable reset", {29'h0, IRQ_RST}, rd)
		axr(8'h40, rd, rsp);
		`CHK("unmapped read", {RESP_ERR, 32'h0}, {rsp, rd})
		axw(8'h40, 32'h1, rsp);
		`CHK("unmapped write", RESP_ERR, rsp)
		@(posedge aclk);
		uart_serial_input <= 1'b1;
		@(posedge aclk);
		uart_serial_input <= 1'b0;
		axw(CTRL_OFS, 32'h2, rsp);
		axr(STATUS_OFS, rd, rsp);
		`CHK("ready after command", 1'b1, rd[ST_READY])
		@(negedge aclk);
		`CHK("run on command", 1'b1, run_hold)
		@(posedge aclk);
		busy <= 1'b1;
		repeat (6) @(posedge aclk);
		axr(STATUS_OFS, rd, rsp);
		`CHK("busy clears ready", 2'b01, rd[1:0])
		@(negedge aclk);
		`CHK("hold", 1'b0, run_hold)
		@(posedge aclk);
		busy <= 1'b0;
		axw(CTRL_OFS, 32'h3, rsp);
		repeat (3) @(negedge aclk);
		`CHK("run on start write", 1'b1, run_hold)
		@(posedge aclk);
		busy <= 1'b1;
		repeat (6) @(posedge aclk);
		busy <= 1'b0;
		axw(CTRL_OFS, 32'h0, rsp);
		burst(1'b1, 1'b0, 1'b0, GAP);
		axr(IRQ_STAT_OFS, rd, rsp);
		`CHK("irq status", 4'h6, {rd[2:0], irq})
		axw(IRQ_EN_OFS, 32'h2, rsp);
		@(negedge aclk);
		`CHK("irq enabled", 1'b1, irq)
		axw(IRQ_CLR_OFS, 32'h7, rsp);
		@(negedge aclk);
		`CHK("irq cleared", 1'b0, irq)
		mg = 1'b1;
		axw(CTRL_OFS, 32'h4, rsp);
		burst(1'b0, 1'b0, 1'b1, GAP);
		burst(1'b1, 1'b1, 1'b0, GAP);
		db = display_blank;
		burst(1'b1, 1'b1, 1'b0, GAP);
		`CHK("blank alternates", ~db, display_blank)
		burst(1'b0, 1'b0, 1'b0, 60);
		axr(IRQ_STAT_OFS, rd, rsp);
		`CHK("overrun flagged", 1'b1, rd[IRQ_OVERRUN])
		`CHK("conversion tick", 1'b1, ticks > 0)
		stop_test();
	end
endmodule : testbench
`default_nettype wire
